/* File: hdl/serial_regs_pkg.sv */
// Constants and types shared by the serial register write block
package serial_regs_pkg;

  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 28;
  localparam int CNT_W       = 6;
  localparam int BASE_W      = 16;
  localparam int GRP_CNT_W   = 8;
  localparam int PAT_CNT_LSB = 0;
  localparam int SEQ_CNT_LSB = 8;
  localparam int DELAY_W     = 12;
  localparam int DELAY_LSB   = 0;

  // Frame bit positions: address bits 0..11, data bits 12..39
  localparam logic [CNT_W-1:0] ADDR_LAST_BIT  = 6'h0b;
  localparam logic [CNT_W-1:0] DATA_FIRST_BIT = 6'h0c;
  localparam logic [CNT_W-1:0] FRAME_LAST_BIT = 6'h27;

  // Address map
  localparam logic [ADDR_W-1:0] FIXED_LAST  = 12'h0ff;
  localparam logic [ADDR_W-1:0] CFG_BASE    = 12'h400;
  localparam logic [ADDR_W-1:0] STANDBY_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] OUTCTL_ADDR = 12'h001;
  localparam logic [ADDR_W-1:0] SPARE_ADDR  = 12'h00b;
  localparam logic [ADDR_W-1:0] DELAY_ADDR  = 12'h017;
  localparam logic [ADDR_W-1:0] COUNTS_ADDR = 12'h028;
  localparam logic [ADDR_W-1:0] SG_FIRST    = 12'h0e0;
  localparam logic [ADDR_W-1:0] SG_LAST     = 12'h0e3;

  // Span of one pattern group and one sequence, in addresses
  localparam logic [BASE_W-1:0] PAT_SPAN = 16'h0030;
  localparam logic [BASE_W-1:0] SEQ_SPAN = 16'h0028;

  // Update classes, one bit each so they can form a mask
  typedef logic [4:0] upd_cls_t;
  localparam upd_cls_t CLS_NONE  = 5'h00;
  localparam upd_cls_t CLS_SCK   = 5'h01;
  localparam upd_cls_t CLS_VD    = 5'h02;
  localparam upd_cls_t CLS_FIELD = 5'h04;
  localparam upd_cls_t CLS_SG    = 5'h08;
  localparam upd_cls_t CLS_SCP   = 5'h10;

  typedef enum logic [1:0] {
    SWEEP_IDLE = 2'b01,
    SWEEP_RUN  = 2'b10
  } sweep_state_t;

endpackage

/* File: hdl/sync_two_flop.sv */
// Two flip-flop level synchroniser, one per bit
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  // Clock and reset of the receiving domain
  input  wire logic             clk,
  input  wire logic             rst,
  // Level in and synchronised level out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync_two_flop: WIDTH must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end

endmodule // sync_two_flop

/* File: hdl/commit_sweeper.sv */
// Walks every register index once per start, one index a cycle
module commit_sweeper
  import serial_regs_pkg::*;
#(
  parameter int DEPTH = 4096,
  parameter int IDX_W = 12
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Control
  input  wire logic             start,
  output logic                  busy,
  output logic      [IDX_W-1:0] idx
);

  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);

  sweep_state_t     state_ff;
  logic [IDX_W-1:0] idx_ff;

  if (DEPTH < 2 || DEPTH > (1 << IDX_W)) begin : g_bad_depth
    $error("commit_sweeper: DEPTH does not fit IDX_W");
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= SWEEP_IDLE;
    end else begin
      unique case (state_ff)
        SWEEP_IDLE: if (start) state_ff <= SWEEP_RUN;
        SWEEP_RUN:  if (idx_ff == IDX_LAST) state_ff <= SWEEP_IDLE;
        default:    state_ff <= SWEEP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_ff == SWEEP_IDLE) begin
      idx_ff <= '0;
    end else begin
      idx_ff <= idx_ff + 1'b1;
    end
  end

  assign busy = (state_ff == SWEEP_RUN);
  assign idx  = idx_ff;

endmodule // commit_sweeper

/* File: hdl/serial_register_write_and_update.sv */
// Serial 3-wire register write port with staged update points
module serial_register_write_and_update
  import serial_regs_pkg::*;
#(
  parameter int NUM_WORDS = 4096
) (
  // Core clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Serial port
  input  wire logic              serialClk,
  input  wire logic              serialData,
  input  wire logic              serialLoadStrobeN,
  // Timing events from the sensor timing logic
  input  wire logic              verticalSync,
  input  wire logic              horizontalSync,
  input  wire logic              sensorGate,
  input  wire logic              seqChangePos,
  // Register readback
  input  wire logic [ADDR_W-1:0] readAddr,
  output logic      [DATA_W-1:0] readData,
  // Layout and status
  output logic      [BASE_W-1:0] sequenceBase,
  output logic      [BASE_W-1:0] fieldBase,
  output logic                   commitBusy,
  output logic                   updatePending
);

  if (NUM_WORDS != (1 << ADDR_W)) begin : g_bad_words
    $error("NUM_WORDS must cover the whole address space");
  end

  // ---------------- Serial clock domain ----------------

  logic [CNT_W-1:0]  bitCnt_ff;
  logic [ADDR_W-1:0] addrSh_ff;
  logic [DATA_W-1:0] dataSh_ff;
  logic [ADDR_W-1:0] wordAddr_ff;
  logic [DATA_W-1:0] wordData_ff;
  logic              wordTog_ff;
  logic              linkRst;
  logic              frameLast;
  logic              inAddr;

  assign frameLast = (bitCnt_ff == FRAME_LAST_BIT);
  assign inAddr    = (bitCnt_ff <= ADDR_LAST_BIT);

  // Reset reaches the link side only while its clock runs
  sync_two_flop #(
    .WIDTH (1)
  ) u_link_rst (
    .clk  (serialClk),
    .rst  (1'b0),
    .din  (srst),
    .dout (linkRst)
  );

  // Strobe high clears the count, so a cut word is never handed on
  always_ff @(posedge serialClk or posedge serialLoadStrobeN) begin
    if (serialLoadStrobeN) begin
      bitCnt_ff <= '0;
    end else if (frameLast) begin
      bitCnt_ff <= DATA_FIRST_BIT;
    end else begin
      bitCnt_ff <= bitCnt_ff + 1'b1;
    end
  end

  always_ff @(posedge serialClk or posedge serialLoadStrobeN) begin
    if (serialLoadStrobeN) begin
      addrSh_ff <= '0;
    end else if (inAddr) begin
      addrSh_ff <= {serialData, addrSh_ff[ADDR_W-1:1]};
    end else if (frameLast) begin
      addrSh_ff <= addrSh_ff + 1'b1;
    end
  end

  always_ff @(posedge serialClk or posedge serialLoadStrobeN) begin
    if (serialLoadStrobeN) begin
      dataSh_ff <= '0;
    end else if (!inAddr) begin
      dataSh_ff <= {serialData, dataSh_ff[DATA_W-1:1]};
    end
  end

  // Word handed to the core by a toggle; held for a whole word time
  always_ff @(posedge serialClk) begin
    if (linkRst) begin
      wordAddr_ff <= '0;
      wordData_ff <= '0;
      wordTog_ff  <= 1'b0;
    end else if (frameLast && !serialLoadStrobeN) begin
      wordAddr_ff <= addrSh_ff;
      wordData_ff <= {serialData, dataSh_ff[DATA_W-1:1]};
      wordTog_ff  <= ~wordTog_ff;
    end
  end

  // ---------------- Core clock domain ----------------

  logic       togSync;
  logic       togPrev_ff;
  logic       wordFire;
  logic [3:0] pinSync;
  logic [3:0] pinPrev_ff;
  logic       vdFall;
  logic       hdFall;
  logic       sgLine;
  logic       scpRise;

  sync_two_flop #(
    .WIDTH (1)
  ) u_tog_sync (
    .clk  (core_clk),
    .rst  (srst),
    .din  (wordTog_ff),
    .dout (togSync)
  );

  sync_two_flop #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk  (core_clk),
    .rst  (srst),
    .din  ({verticalSync, horizontalSync, sensorGate, seqChangePos}),
    .dout (pinSync)
  );

  // Following the toggle during reset avoids a false word afterwards
  always_ff @(posedge core_clk) begin
    togPrev_ff <= togSync;
  end

  always_ff @(posedge core_clk) begin
    pinPrev_ff <= pinSync;
  end

  assign wordFire = (togSync != togPrev_ff) && !srst;
  assign vdFall   = pinPrev_ff[3] && !pinSync[3];
  assign hdFall   = pinPrev_ff[2] && !pinSync[2];
  assign sgLine   = hdFall && pinSync[1];
  assign scpRise  = !pinPrev_ff[0] && pinSync[0];

  // ---------------- Layout registers ----------------

  logic [DELAY_W-1:0]   lineDelay_ff;
  logic [GRP_CNT_W-1:0] patCnt_ff;
  logic [GRP_CNT_W-1:0] seqCnt_ff;
  logic [BASE_W-1:0]    seqBase_ff;
  logic [BASE_W-1:0]    fieldBase_ff;

  function automatic upd_cls_t addrClass(
    input logic [ADDR_W-1:0] a,
    input logic [BASE_W-1:0] fieldB
  );
    upd_cls_t c;
    c = CLS_NONE;
    if (a <= FIXED_LAST) begin
      if (a == STANDBY_ADDR || a == OUTCTL_ADDR || a == SPARE_ADDR ||
          a == DELAY_ADDR || a == COUNTS_ADDR) begin
        c = CLS_SCK;
      end else if (a >= SG_FIRST && a <= SG_LAST) begin
        c = CLS_SG;
      end else begin
        c = CLS_VD;
      end
    end else if (a < CFG_BASE) begin
      c = CLS_NONE;
    end else if ({{(BASE_W-ADDR_W){1'b0}}, a} < fieldB) begin
      c = CLS_SCP;
    end else begin
      c = CLS_FIELD;
    end
    return c;
  endfunction

  upd_cls_t fireCls;
  logic     fireLive;
  logic     fireStage;

  assign fireCls   = addrClass(wordAddr_ff, fieldBase_ff);
  assign fireLive  = wordFire && (fireCls == CLS_SCK);
  assign fireStage = wordFire && (fireCls != CLS_SCK) && (fireCls != CLS_NONE);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lineDelay_ff <= '0;
      patCnt_ff    <= '0;
      seqCnt_ff    <= '0;
    end else if (fireLive && wordAddr_ff == DELAY_ADDR) begin
      lineDelay_ff <= wordData_ff[DELAY_LSB +: DELAY_W];
    end else if (fireLive && wordAddr_ff == COUNTS_ADDR) begin
      patCnt_ff <= wordData_ff[PAT_CNT_LSB +: GRP_CNT_W];
      seqCnt_ff <= wordData_ff[SEQ_CNT_LSB +: GRP_CNT_W];
    end
  end

  // Sequence base follows the counts one cycle later, field base two cycles later
  always_ff @(posedge core_clk) begin
    if (srst) begin
      seqBase_ff   <= {{(BASE_W-ADDR_W){1'b0}}, CFG_BASE};
      fieldBase_ff <= {{(BASE_W-ADDR_W){1'b0}}, CFG_BASE};
    end else begin
      seqBase_ff <= {{(BASE_W-ADDR_W){1'b0}}, CFG_BASE}
                  + {{(BASE_W-GRP_CNT_W){1'b0}}, patCnt_ff} * PAT_SPAN;
      fieldBase_ff <= seqBase_ff
                    + {{(BASE_W-GRP_CNT_W){1'b0}}, seqCnt_ff} * SEQ_SPAN;
    end
  end

  // ---------------- Delayed vertical update ----------------

  logic [DELAY_W-1:0] linesLeft_ff;
  logic               delayArmed_ff;
  logic               delayHit;

  assign delayHit = delayArmed_ff && hdFall && !vdFall
                  && (linesLeft_ff == DELAY_W'(1));

  always_ff @(posedge core_clk) begin
    if (srst) begin
      delayArmed_ff <= 1'b0;
      linesLeft_ff  <= '0;
    end else if (vdFall) begin
      delayArmed_ff <= (lineDelay_ff != '0);
      linesLeft_ff  <= lineDelay_ff;
    end else if (delayArmed_ff && hdFall) begin
      delayArmed_ff <= (linesLeft_ff != DELAY_W'(1));
      linesLeft_ff  <= linesLeft_ff - 1'b1;
    end
  end

  // ---------------- Commit requests ----------------

  upd_cls_t newEvents;
  upd_cls_t req_ff;
  upd_cls_t sweepMask_ff;
  logic     sweepBusy;
  logic     startSweep;
  logic [ADDR_W-1:0] sweepIdx;

  always_comb begin
    newEvents = CLS_NONE;
    if (vdFall) begin
      newEvents = newEvents | CLS_FIELD;
    end
    if ((vdFall && lineDelay_ff == '0) || delayHit) begin
      newEvents = newEvents | CLS_VD;
    end
    if (sgLine) begin
      newEvents = newEvents | CLS_SG;
    end
    if (scpRise) begin
      newEvents = newEvents | CLS_SCP;
    end
  end

  assign startSweep = !sweepBusy && (req_ff != CLS_NONE);

  // Events landing while a sweep is taken are kept for the next one
  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_ff       <= CLS_NONE;
      sweepMask_ff <= CLS_NONE;
    end else if (startSweep) begin
      req_ff       <= newEvents;
      sweepMask_ff <= req_ff;
    end else begin
      req_ff <= req_ff | newEvents;
    end
  end

  // One full pass per request; close events merge into one pass
  commit_sweeper #(
    .DEPTH (NUM_WORDS),
    .IDX_W (ADDR_W)
  ) u_sweeper (
    .clk   (core_clk),
    .srst  (srst),
    .start (startSweep),
    .busy  (sweepBusy),
    .idx   (sweepIdx)
  );

  // ---------------- Register storage ----------------

  logic [DATA_W-1:0]    liveMem   [NUM_WORDS];
  logic [DATA_W-1:0]    stagedMem [NUM_WORDS];
  logic [NUM_WORDS-1:0] pend_ff;
  logic [NUM_WORDS-1:0] liveValid_ff;
  upd_cls_t             sweepCls;
  logic                 commitNow;

  assign sweepCls  = addrClass(sweepIdx, fieldBase_ff);
  assign commitNow = sweepBusy && pend_ff[sweepIdx]
                   && ((sweepCls & sweepMask_ff) != CLS_NONE);

  always_ff @(posedge core_clk) begin
    if (fireLive) begin
      liveMem[wordAddr_ff] <= wordData_ff;
    end
    if (commitNow) begin
      liveMem[sweepIdx] <= stagedMem[sweepIdx];
    end
  end

  // A later write simply replaces the staged word
  always_ff @(posedge core_clk) begin
    if (fireStage) begin
      stagedMem[wordAddr_ff] <= wordData_ff;
    end
  end

  // Set after clear: a write in the commit cycle stays pending
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pend_ff <= '0;
    end else begin
      if (commitNow) begin
        pend_ff[sweepIdx] <= 1'b0;
      end
      if (fireStage) begin
        pend_ff[wordAddr_ff] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      liveValid_ff <= '0;
    end else begin
      if (fireLive) begin
        liveValid_ff[wordAddr_ff] <= 1'b1;
      end
      if (commitNow) begin
        liveValid_ff[sweepIdx] <= 1'b1;
      end
    end
  end

  // ---------------- Outputs ----------------

  always_ff @(posedge core_clk) begin
    if (srst) begin
      readData <= '0;
    end else if (liveValid_ff[readAddr]) begin
      readData <= liveMem[readAddr];
    end else begin
      readData <= '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      updatePending <= 1'b0;
    end else begin
      updatePending <= (pend_ff != '0);
    end
  end

  assign sequenceBase = seqBase_ff;
  assign fieldBase    = fieldBase_ff;
  assign commitBusy   = sweepBusy;

endmodule // serial_register_write_and_update

/* File: tb/serial_host_model.sv */
// Host side of the 3-wire serial port: frames and link clock
module serial_host_model
  import serial_regs_pkg::*;
(
  // Serial port toward the device
  output logic serialClk,
  output logic serialData,
  output logic serialLoadStrobeN
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    serialLoadStrobeN = 1'b1;
  end

  // Link clock pulses with strobe high, used only around reset
  task automatic tick(input int n);
    repeat (n) begin
      #7.5 serialClk = 1'b1;
      #7.5 serialClk = 1'b0;
    end
  endtask

  // Address then whole words, dropping cut bits from the tail
  task automatic send(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] w[$],
                      input int cut);
    logic bits[$];
    for (int i = 0; i < ADDR_W; i++)
      bits.push_back(addr[i]);
    foreach (w[k])
      for (int i = 0; i < DATA_W; i++)
        bits.push_back(w[k][i]);
    repeat (cut)
      void'(bits.pop_back());
    // Odd offset keeps link edges unrelated to the core clock
    #3.1 serialLoadStrobeN = 1'b0;
    foreach (bits[i]) begin
      serialData = bits[i];
      #7.5 serialClk = 1'b1;
      #7.5 serialClk = 1'b0;
    end
    #7.5 serialLoadStrobeN = 1'b1;
    // Released line shows no stale bit
    serialData = ~serialData;
  endtask
endmodule // serial_host_model

/* File: tb/serial_register_write_and_update_monitor.sv */
// Port-level assertions for the serial register write block
module serial_register_write_and_update_monitor
  import serial_regs_pkg::*;
#(
  parameter int NUM_WORDS = 4096
) (
  // Core clock and reset
  input wire logic              core_clk,
  input wire logic              srst,
  // Serial port
  input wire logic              serialClk,
  input wire logic              serialData,
  input wire logic              serialLoadStrobeN,
  // Timing events
  input wire logic              verticalSync,
  input wire logic              horizontalSync,
  input wire logic              sensorGate,
  input wire logic              seqChangePos,
  // Readback and status
  input wire logic [ADDR_W-1:0] readAddr,
  input wire logic [DATA_W-1:0] readData,
  input wire logic [BASE_W-1:0] sequenceBase,
  input wire logic [BASE_W-1:0] fieldBase,
  input wire logic              commitBusy,
  input wire logic              updatePending
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [12:0] busyCnt_ff;
  logic [12:0] nxt_busyCnt;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  always_comb nxt_busyCnt = commitBusy ? busyCnt_ff + 13'h0001 : 13'h0000;
  always_ff @(posedge core_clk) begin
    if (srst)
      busyCnt_ff <= 13'h0000;
    else
      busyCnt_ff <= nxt_busyCnt;
  end

  // Serial idle, no sweep, address held: nothing may move readData
  sequence s_quiet;
    (serialLoadStrobeN && !commitBusy && $stable(readAddr)) [*8];
  endsequence
  sequence s_sweep_start;
    ##[1:10] commitBusy;
  endsequence

  AST_RESET_OUT: assert property (disable iff (1'b0) srst |=> readData == '0
      && !commitBusy && !updatePending && sequenceBase == 16'h0400 && fieldBase == 16'h0400)
    else $error("outputs not cleared by reset");
  AST_SEQ_BASE: assert property (sequenceBase >= 16'h0400
      && (sequenceBase - 16'h0400) % 48 == 0)
    else $error("sequence base off the group grid");
  AST_FIELD_BASE: assert property ($stable(sequenceBase) [*4] |->
      fieldBase >= sequenceBase && (fieldBase - sequenceBase) % 40 == 0)
    else $error("field base off the sequence grid");
  AST_BUSY_LEN: assert property ($fell(commitBusy) |-> busyCnt_ff == 13'(NUM_WORDS))
    else $error("sweep length wrong");
  AST_BUSY_MAX: assert property (busyCnt_ff <= 13'(NUM_WORDS))
    else $error("sweep overran");
  AST_VSYNC_SWEEP: assert property ($fell(verticalSync) && !commitBusy |-> s_sweep_start)
    else $error("no sweep after vsync fall");
  AST_SG_SWEEP: assert property ($fell(horizontalSync) && sensorGate && !commitBusy
      |-> s_sweep_start)
    else $error("no sweep at sensor-gate line");
  AST_SCP_SWEEP: assert property ($rose(seqChangePos) && !commitBusy |-> s_sweep_start)
    else $error("no sweep at change position");
  AST_READ_HOLD: assert property (s_quiet |=> $stable(readData))
    else $error("readData moved while idle");
endmodule // serial_register_write_and_update_monitor

bind serial_register_write_and_update serial_register_write_and_update_monitor #(
  .NUM_WORDS(NUM_WORDS)
) mon_u (
  .core_clk(core_clk), .srst(srst), .serialClk(serialClk), .serialData(serialData),
  .serialLoadStrobeN(serialLoadStrobeN), .verticalSync(verticalSync),
  .horizontalSync(horizontalSync), .sensorGate(sensorGate), .seqChangePos(seqChangePos),
  .readAddr(readAddr), .readData(readData), .sequenceBase(sequenceBase),
  .fieldBase(fieldBase), .commitBusy(commitBusy), .updatePending(updatePending)
);

/* File: tb/serial_register_write_and_update_test.sv */
// Self-checking bench for the serial register write block
module serial_register_write_and_update_test;
  import serial_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic              core_clk = 1'b0;
  logic              srst = 1'b1;
  logic              serialClk;
  logic              serialData;
  logic              serialLoadStrobeN;
  logic              verticalSync = 1'b1;
  logic              horizontalSync = 1'b1;
  logic              sensorGate = 1'b0;
  logic              seqChangePos = 1'b0;
  logic [ADDR_W-1:0] readAddr = '0;
  logic [DATA_W-1:0] readData;
  logic [BASE_W-1:0] sequenceBase;
  logic [BASE_W-1:0] fieldBase;
  logic              commitBusy;
  logic              updatePending;
  int                bad_count = 0;
  int                checks = 0;
  int                seed = 62634;

  always #2.5 core_clk = ~core_clk;

  serial_host_model host_u (.serialClk(serialClk), .serialData(serialData),
    .serialLoadStrobeN(serialLoadStrobeN));

  serial_register_write_and_update #(.NUM_WORDS(4096)) dut_u (
    .core_clk(core_clk), .srst(srst), .serialClk(serialClk), .serialData(serialData),
    .serialLoadStrobeN(serialLoadStrobeN), .verticalSync(verticalSync),
    .horizontalSync(horizontalSync), .sensorGate(sensorGate), .seqChangePos(seqChangePos),
    .readAddr(readAddr), .readData(readData), .sequenceBase(sequenceBase),
    .fieldBase(fieldBase), .commitBusy(commitBusy), .updatePending(updatePending));

  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'($random(seed));
  endfunction
  function automatic logic [BASE_W-1:0] seqb(input logic [7:0] g);
    return 16'h0400 + 16'(g) * 16'h0030;
  endfunction
  function automatic logic [BASE_W-1:0] fldb(input logic [7:0] g, input logic [7:0] s);
    return seqb(g) + 16'(s) * 16'h0028;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp);
    @(posedge core_clk);
    readAddr <= addr;
    cyc(2);
    #1 check(readData, exp);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] a,
                    input logic [DATA_W-1:0] b, input int n, input int cut);
    logic [DATA_W-1:0] q[$];
    q.push_back(a);
    if (n > 1)
      q.push_back(b);
    host_u.send(addr, q, cut);
    cyc(10);
  endtask
  // Event kinds: 0 vsync fall, 1 sensor-gate line, 2 change position, 3 plain line
  task automatic ev(input int k);
    @(posedge core_clk);
    sensorGate <= (k == 1);
    cyc(4);
    verticalSync <= (k != 0);
    horizontalSync <= (k == 0 || k == 2);
    seqChangePos <= (k == 2);
    cyc(6);
    verticalSync <= 1'b1;
    horizontalSync <= 1'b1;
    seqChangePos <= 1'b0;
    sensorGate <= 1'b0;
    cyc(6);
  endtask
  task automatic sweep();
    int n;
    n = 0;
    while (commitBusy !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    check(28'(commitBusy), 28'h000_0001);
    while (commitBusy !== 1'b0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    check(28'(commitBusy), 28'h000_0000);
    cyc(4);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end

  initial begin
    logic [DATA_W-1:0] a, b, c, v;
    logic [7:0]        g, s;
    // Link reset needs one serial edge inside reset and two after it
    fork
      host_u.tick(4);
      begin
        cyc(4);
        srst <= 1'b0;
      end
    join
    cyc(2);
    #1 check(28'(sequenceBase), 28'h000_0400);
    check(28'(fieldBase), 28'h000_0400);
    for (int i = 0; i < 4; i++) begin
      g = (i == 3) ? 8'h03 : 8'(rnd() & 28'h000_000f);
      s = (i == 3) ? 8'h04 : 8'(rnd() & 28'h000_000f);
      v = {12'h000, s, g};
      wr(COUNTS_ADDR, v, '0, 1, 0);
      rd(COUNTS_ADDR, v);
      check(28'(sequenceBase), 28'(seqb(g)));
      check(28'(fieldBase), 28'(fldb(g, s)));
    end
    wr(DELAY_ADDR, rnd(), '0, 1, 1);
    rd(DELAY_ADDR, '0);
    wr(12'h100, rnd(), '0, 1, 0);
    rd(12'h100, '0);
    a = rnd();
    b = rnd();
    c = rnd();
    wr(12'h027, a, v, 2, 0);
    rd(COUNTS_ADDR, v);
    rd(12'h027, '0);
    check(28'(updatePending), 28'h000_0001);
    wr(12'hfff, b, c, 2, 0);
    rd(STANDBY_ADDR, c);
    rd(12'hfff, '0);
    wr(DELAY_ADDR, 28'h000_0002, '0, 1, 0);
    ev(0);
    sweep();
    rd(12'hfff, b);
    rd(12'h027, '0);
    ev(3);
    ev(3);
    sweep();
    rd(12'h027, a);
    wr(DELAY_ADDR, '0, '0, 1, 0);
    wr(12'h027, c, '0, 1, 0);
    wr(SG_FIRST, c, '0, 1, 0);
    wr(CFG_BASE, a, '0, 1, 0);
    wr(CFG_BASE, b, '0, 1, 0);
    ev(0);
    sweep();
    rd(12'h027, c);
    rd(SG_FIRST, '0);
    rd(CFG_BASE, '0);
    ev(1);
    sweep();
    rd(SG_FIRST, c);
    rd(CFG_BASE, '0);
    ev(2);
    sweep();
    rd(CFG_BASE, b);
    check(28'(updatePending), '0);
    end_sim();
  end
endmodule // serial_register_write_and_update_test
